// *** bench/sfrwb_bank_tb.sv ***
// self-checking bench for the window-switching bank
`timescale 1ns/1ns
module sfrwb_bank_tb;
  import sfrwb_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, tx_done_set, rx_done_set;
  logic push_all_context, pop_all_context;
  logic [31:0] haddr, hwdata, hrdata, q, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] capture_pins;
  logic [7:0] port_pins, wdt_high, window_select;
  sfrwb_ctx_s ctx_restore, ctx_saved;
  sfrwb_periph_s periph;
  int n_fail, n_checks, cyc, seed;
  int m0[64], m15[64]; // last values per view, model side
  assign hready = hreadyout;
  sfrwb_bank #(.ADDR_W(32)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
    .hreadyout, .hresp, .hrdata, .capture_pins, .port_pins, .wdt_high, .tx_done_set, .rx_done_set,
    .push_all_context, .pop_all_context, .ctx_restore, .ctx_saved, .periph, .window_select);
  sfrwb_core_model core (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // ----
  // model, compare and closing
  // ----
  function automatic logic [31:0] expv(int w, int i);
    case (i)
      2, 3, 4, 5, 7, 'h11, 'h16, 'h17: return w ? m0[i] : m15[i];
      6: return w ? m0[i] : m15[i] | {capture_pins[3], 1'b0, capture_pins[2], 1'b0, capture_pins[1], 1'b0, capture_pins[0], 1'b0};
      'hA: return w ? {24'h0, wdt_high} : m15[i];
      'hB: return w ? m0[i] | 'h80 : m15[i];
      'hC, 'hD: return w ? m15[i] : m0[i];
      'hE: return w ? 0 : {24'h0, port_pins};
      'hF: return w ? 0 : m0[i];
      'h15: return w ? m0[i] | 2 : m15[i];
      8, 9, 'h10, 'h12, 'h13, 'h14, 'h18, 'h19: return m0[i];
      default: return 0;
    endcase
  endfunction : expv
  function automatic void upd(int w, int i, int d);
    if (i inside {8, 9, 'h10, 'h12, 'h13, 'h18, 'h19}) m0[i] = d;
    else if (i < 2 || i > 'h19 || i == 'h14) return;
    else if (w == 0) m0[i] = (i == 'hB) ? d & 'h7F : (i == 'h15) ? d & 'hFD : d;
    else if (i == 6) m15[i] = d & 'h55;
    else if (i == 'h15) m15[i] = d & 'h3F;
    else if (i == 'h11 || i == 'h17) m15[i] |= d;
    else if (i == 'h16) m15[i] |= d & 'h3F;
    else if (i != 'hE && i != 'hF) m15[i] = d;
  endfunction : upd
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input int w, input logic [5:0] i, input logic [7:0] d);
    core.xfer(1'b1, i, d, q);
    upd(w, i, d);
  endtask : wr
  task automatic setwin(input logic [3:0] w);
    wr(0, 6'h14, {4'h0, w});
    m0['h14] = w;
    chk("window", {24'h0, window_select}, {28'h0, w});
  endtask : setwin
  task automatic sweep(input int w);
    for (int i = 0; i < 64; i++) begin
      core.xfer(1'b0, i[5:0], 8'h00, q);
      chk($sformatf("index %0h view %0d", i, w), q, expv(w, i));
    end
  endtask : sweep
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    seed = 32'hbfce;
    {hresetn, tx_done_set, rx_done_set, push_all_context, pop_all_context} = '0;
    {capture_pins, port_pins, wdt_high, ctx_restore} = '0;
    {n_fail, n_checks, cyc} = '0;
    repeat (5) @(posedge hclk);
    r = $random(seed);
    hresetn <= 1'b1;
    capture_pins <= r[3:0];
    port_pins <= r[15:8];
    wdt_high <= r[23:16];
    repeat (4) @(posedge hclk);
    sweep(0);
    $display("test reset values done");
    for (int w = 0; w < 2; w++) begin
      setwin(w ? 4'hF : 4'h0);
      for (int i = 0; i < 64; i++) begin
        r = $random(seed);
        if (i != 'h14) wr(w, i[5:0], r[7:0]);
      end
    end
    chk("scheduler pins", {26'h0, periph.sched_pins}, m15['h15]);
    sweep(1);
    setwin(4'h0);
    sweep(0);
    $display("test window views done");
    tx_done_set <= 1'b1;
    @(posedge hclk);
    tx_done_set <= 1'b0;
    rx_done_set <= 1'b1;
    @(posedge hclk);
    rx_done_set <= 1'b0;
    @(posedge hclk);
    m15['h11] |= 'h60;
    core.xfer(1'b0, 6'h11, 8'h00, q);
    chk("serial status", q, expv(0, 'h11));
    $display("test serial flags done");
    r = $random(seed);
    r[11:8] = {4{r[9]}};
    push_all_context <= 1'b1;
    ctx_restore <= r[15:0];
    @(posedge hclk);
    push_all_context <= 1'b0;
    @(posedge hclk);
    chk("saved context", {16'h0, ctx_saved}, {16'h0, 8'(m0['h14]), 8'(m0['h13])});
    pop_all_context <= 1'b1;
    @(posedge hclk);
    pop_all_context <= 1'b0;
    @(posedge hclk);
    m0['h14] = r[11:8];
    m0['h13] = r[7:0];
    chk("restored window", {24'h0, window_select}, {28'h0, r[11:8]});
    sweep(r[9]);
    $display("test context done");
    give_verdict();
  end
endmodule : sfrwb_bank_tb
bind sfrwb_bank sfrwb_checker #(.ADDR_W(ADDR_W)) chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hwdata, .hreadyout, .hresp, .hrdata, .tx_done_set, .rx_done_set, .push_all_context, .pop_all_context,
  .ctx_restore, .ctx_saved, .periph, .window_select);

// *** bench/sfrwb_checker.sv ***
// assertions on the ports of the window-switching bank
`timescale 1ns/1ns
module sfrwb_checker
  import sfrwb_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic hclk, // bank clock
  input wire logic hresetn, // reset, active low
  input wire logic hsel, // slave select
  input wire logic [ADDR_W-1:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic hready, // bus ready
  input wire logic [31:0] hwdata, // write data
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // response
  input wire logic [31:0] hrdata, // read data
  input wire logic tx_done_set, // transmit flag event
  input wire logic rx_done_set, // receive flag event
  input wire logic push_all_context, // save pulse
  input wire logic pop_all_context, // restore pulse
  input wire sfrwb_ctx_s ctx_restore, // restore value
  input wire sfrwb_ctx_s ctx_saved, // saved value
  input wire sfrwb_periph_s periph, // peripheral side
  input wire logic [7:0] window_select // window byte
);
  // ----
  // helpers and properties
  // ----
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic tk; // transfer taken this edge
  logic [5:0] ix; // register index
  logic [7:0] rwin; // window byte offered on restore
  logic w15; // alternate view active
  assign tk = hsel && hready && htrans[1];
  assign ix = haddr[7:2];
  assign rwin = ctx_restore.window_sel;
  assign w15 = window_select[3:0] == 4'hF;
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_zero; tk && !hwrite && ix < 6'h02 |=> hrdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("zero register not zero");
  property p_winhi; window_select[7:4] == 4'h0; endproperty
  a_winhi: assert property (p_winhi) else $error("window upper bits set");
  property p_wstall; tk && hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_wstall: assert property (p_wstall) else $error("write wait state wrong");
  property p_winwr;
    tk && hwrite && ix == 6'h14 && haddr[ADDR_W-1:8] == '0 |-> ##3 {24'h0, window_select} == ($past(hwdata) & 32'hF);
  endproperty
  a_winwr: assert property (p_winwr) else $error("window write lost");
  property p_push; push_all_context |=> ctx_saved.window_sel == $past(window_select); endproperty
  a_push: assert property (p_push) else $error("window not saved");
  property p_pop; pop_all_context |=> window_select == ($past(rwin) & 8'h0F); endproperty
  a_pop: assert property (p_pop) else $error("window not restored");
  property p_irq; periph.serial_irq == ($past(tx_done_set) || $past(rx_done_set)); endproperty
  a_irq: assert property (p_irq) else $error("serial event without flag");
  property p_w15e; tk && !hwrite && w15 && ix == 6'h0E |=> hrdata == 32'h0; endproperty
  a_w15e: assert property (p_w15e) else $error("dead place read nonzero");
  property p_w15f; tk && !hwrite && w15 && ix == 6'h0F |=> hrdata == 32'h0; endproperty
  a_w15f: assert property (p_w15f) else $error("blocked port read nonzero");
  property p_flush;
    tk && hwrite && ix == 6'h0B && !w15 ##1 1'b1 |=> periph.table_flush == $past(hwdata[7]);
  endproperty
  a_flush: assert property (p_flush) else $error("table flush strobe wrong");
  property p_tclr;
    tk && hwrite && ix == 6'h15 && !w15 ##1 1'b1 |=> periph.t2_clear == $past(hwdata[1]);
  endproperty
  a_tclr: assert property (p_tclr) else $error("timer clear strobe wrong");
  c_w15wr: cover property (tk && hwrite && w15);
  c_irq: cover property (periph.serial_irq);
  c_pop: cover property (pop_all_context);
endmodule : sfrwb_checker

// *** bench/sfrwb_core_model.sv ***
// register master standing in for the core on the bus
`timescale 1ns/1ns
module sfrwb_core_model (
  input wire logic hclk, // bus clock
  input wire logic hready, // bus ready
  input wire logic [31:0] hrdata, // read data
  output logic hsel, // select, kept high
  output logic [31:0] haddr, // byte address
  output logic [1:0] htrans, // transfer type
  output logic hwrite, // write when high
  output logic [2:0] hsize, // word only
  output logic [31:0] hwdata // write data
);
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one word transfer; called just after a rising edge, holds each phase until ready
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d, output logic [31:0] q);
    haddr <= {24'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
endmodule : sfrwb_core_model

// *** rtl/sfrwb_bank.sv ***
// special-function register bank with two switchable views, reached over AHB-Lite
// ------------------------------------------------------------
// Summary of operation
// - only windows 0 and 15 act
// - window 0: shared offset reads one, writes another
// - window 15 swaps read-only and write-only sides
// - window 15: 0C/0D reach second timer capture
// - window 15: 02 reads command, writes load result
// - window 15: 03 reads capture mode setting
// - window 15: capture time writable, scheduler holding readable
// - window 15: capture status keeps pin bits 1,3,5,7
// - window 15: 07 write receive, read transmit
// - window 15: 0A reads watchdog high, writes timer
// - io control readback; two strobe bits read one
// - window 15: 0E has no function
// - window 15: second port fully blocked
// - window 15: serial status set without interrupt
// - window 15: 11 reads serial control byte
// - window 15: 15 drives scheduler pins, bits 6-7 ignored
// - window 15: 16/17 set status, no interrupt
// - window 15: 17 reads duty cycle value
// - reserved places read zero, never written
// - push/pop all saves window and enable high
// ------------------------------------------------------------
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module sfrwb_bank
  import sfrwb_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic hclk,                     // bank clock, 50 MHz
  input wire logic hresetn,                  // async reset, active low
  input wire logic hsel,                     // slave select
  input wire logic [ADDR_W-1:0] haddr,       // byte address
  input wire logic [1:0] htrans,             // transfer type
  input wire logic hwrite,                   // write when high
  input wire logic [2:0] hsize,              // transfer size, word only
  input wire logic hready,                   // bus ready
  input wire logic [31:0] hwdata,            // write data
  output logic hreadyout,                    // slave ready
  output logic hresp,                        // always okay
  output logic [31:0] hrdata,                // read data
  input wire logic [3:0] capture_pins,       // capture input pin levels, async
  input wire logic [7:0] port_pins,          // first port pin levels, async
  input wire logic [7:0] wdt_high,           // watchdog_counter upper byte
  input wire logic tx_done_set,              // serial transmitter finished, pulse
  input wire logic rx_done_set,              // serial receiver finished, pulse
  input wire logic push_all_context,         // core saves context, pulse
  input wire logic pop_all_context,          // core restores context, pulse
  input wire sfrwb_ctx_s ctx_restore,        // context restored on pop
  output sfrwb_ctx_s ctx_saved,              // context captured on push
  output sfrwb_periph_s periph,              // pins and strobes to peripherals
  output logic [7:0] window_select           // current window select byte
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NUM_IDX-1:0][7:0] rd_side;        // read side, also home of read/write registers
    logic [NUM_IDX-1:0][7:0] wr_side;        // write side of shared offsets
    logic [1:0][7:0] second_timer_capture;             // second_timer_capture bytes
    logic wr_pend;                           // write data phase in progress
    logic wr_ok;                             // pending write hits a mapped index
    logic [IDX_W-1:0] wr_idx;                // pending write index
    logic [31:0] hrdata;                     // read data register
    logic hready;                            // ready register
    logic hresp;                             // response register
    sfrwb_periph_s periph;                   // peripheral outputs
    sfrwb_ctx_s ctx;                         // saved context
  } sfrwb_state_s;

  sfrwb_state_s st_q;
  sfrwb_state_s st_d;
  logic [11:0] pins_sync;                    // synchronised pin levels
  logic [3:0] cap_pins;                      // capture pins, settled
  logic [7:0] port_in;                       // port pins, settled

  // refuse an address too narrow to hold the index field
  if (ADDR_W < IDX_LSB + IDX_W) begin : g_bad_addr_w
    $error("sfrwb_bank: ADDR_W too small");
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  sfrwb_pin_sync #(.WIDTH(12)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({capture_pins, port_pins}),
    .sync_out(pins_sync)
  );
  assign cap_pins = pins_sync[11:8];
  assign port_in = pins_sync[7:0];

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // offset with separate read and write registers in window 0
  function automatic logic is_shared(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_CONV_LO, IDX_CONV_HI, IDX_EVT_LO, IDX_EVT_HI, IDX_CAP_STATUS, IDX_SERIAL_BUF,
      IDX_TMR_A_LO, IDX_TMR_A_HI, IDX_PIN_IN, IDX_SER_STATUS,
      IDX_IOST_A, IDX_IOST_B, IDX_IOST_C: is_shared = 1'b1;
      default: is_shared = 1'b0;
    endcase
  endfunction : is_shared

  // word address inside the bank and aligned; the zero register counts as mapped
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[IDX_LSB +: IDX_W];
    addr_mapped = (a[1:0] == 2'h0) && ((a >> (IDX_LSB + IDX_W)) == '0)
                  && (int'(idx) < NUM_IDX);
  endfunction : addr_mapped

  // window 15 is the only alternate; any other value acts as window 0
  function automatic logic alt_view(input logic [7:0] wsel);
    alt_view = (wsel[3:0] == WIN_ALT);
  endfunction : alt_view

  // ------------------------------------------------------------
  // read value of one index in the current window
  // ------------------------------------------------------------
  function automatic logic [7:0] read_byte(input sfrwb_state_s s, input logic [IDX_W-1:0] idx,
                                           input logic [3:0] cpin, input logic [7:0] pin,
                                           input logic [7:0] wdt);
    logic [7:0] v;
    v = s.rd_side[idx];
    if (idx == IDX_ZERO_LO || idx == IDX_ZERO_HI) begin
      v = REG_RST;
    end else if (!alt_view(s.rd_side[IDX_WINDOW])) begin
      // normal view: read side of shared offsets
      if (idx == IDX_PIN_IN) begin
        v = pin;
      end else if (idx == IDX_CAP_STATUS) begin
        v = (s.rd_side[idx] & ~CAP_PIN_MASK)
            | ({cpin[3], 1'b0, cpin[2], 1'b0, cpin[1], 1'b0, cpin[0], 1'b0} & CAP_PIN_MASK);
      end else begin
        v = s.rd_side[idx];
      end
    end else begin
      case (idx)
        IDX_TMR_B_LO: v = s.second_timer_capture[0];
        IDX_TMR_B_HI: v = s.second_timer_capture[1];
        IDX_PIN_IN: v = RSVD_READ;
        IDX_PORT_B: v = RSVD_READ;
        IDX_TMR_A_LO: v = wdt;
        IDX_TMR_A_HI: v = s.wr_side[idx] | FLUSH_MASK;
        IDX_IOST_A: v = s.wr_side[idx] | TCLR_MASK;
        default: begin
          // command, mode, holding registers, tx buffer, serial control, duty cycle
          if (is_shared(idx)) v = s.wr_side[idx];
          else v = s.rd_side[idx];
        end
      endcase
    end
    read_byte = v;
  endfunction : read_byte

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  // writes take one wait state so a following read sees the new value
  always_comb begin
    logic [7:0] wd;
    logic [IDX_W-1:0] wi;
    logic alt;
    wd = hwdata[7:0];
    wi = st_q.wr_idx;
    alt = alt_view(st_q.rd_side[IDX_WINDOW]);
    st_d = st_q;
    st_d.periph.table_flush = 1'b0;                            // strobes last one cycle
    st_d.periph.t2_clear = 1'b0;
    st_d.periph.serial_irq = 1'b0;
    st_d.hresp = 1'b0;

    // address phase
    if (st_q.wr_pend) begin
      st_d.wr_pend = 1'b0;
      st_d.hready = 1'b1;
    end else if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        st_d.wr_pend = 1'b1;
        st_d.wr_ok = addr_mapped(haddr);
        st_d.wr_idx = haddr[IDX_LSB +: IDX_W];
        st_d.hready = 1'b0;
      end else if (addr_mapped(haddr)) begin
        st_d.hrdata = {24'h000000,
                       read_byte(st_q, haddr[IDX_LSB +: IDX_W], cap_pins, port_in, wdt_high)};
      end else begin
        st_d.hrdata = 32'h00000000;                            // unmapped reads zero
      end
    end

    // data phase of a write
    if (st_q.wr_pend && st_q.wr_ok && wi != IDX_ZERO_LO && wi != IDX_ZERO_HI) begin
      if (!alt) begin
        case (wi)
          IDX_TMR_A_HI: begin
            st_d.wr_side[wi] = wd & ~FLUSH_MASK;
            st_d.periph.table_flush = wd[7];
          end
          IDX_IOST_A: begin
            st_d.wr_side[wi] = wd & ~TCLR_MASK;
            st_d.periph.t2_clear = wd[1];
          end
          IDX_WINDOW: st_d.rd_side[wi] = wd & WIN_MASK;
          default: begin
            if (is_shared(wi)) st_d.wr_side[wi] = wd;
            else st_d.rd_side[wi] = wd;
          end
        endcase
      end else begin
        case (wi)
          IDX_TMR_B_LO: st_d.second_timer_capture[0] = wd;
          IDX_TMR_B_HI: st_d.second_timer_capture[1] = wd;
          IDX_PIN_IN, IDX_PORT_B: begin
            // reserved here: written data is dropped
          end
          IDX_CAP_STATUS: st_d.rd_side[wi] = wd & ~CAP_PIN_MASK;
          IDX_SER_STATUS: st_d.rd_side[wi] = st_q.rd_side[wi] | wd;
          IDX_IOST_A: begin
            st_d.rd_side[wi] = (st_q.rd_side[wi] & ~IOST_WR_MASK) | (wd & IOST_WR_MASK);
            st_d.periph.sched_pins = wd[5:0];
          end
          IDX_IOST_B: st_d.rd_side[wi] = st_q.rd_side[wi] | (wd & IOST_WR_MASK);
          IDX_IOST_C: st_d.rd_side[wi] = st_q.rd_side[wi] | wd;
          IDX_WINDOW: st_d.rd_side[wi] = wd & WIN_MASK;
          default: st_d.rd_side[wi] = wd;
        endcase
      end
    end

    // hardware flags are set after the bus write, so a set is never lost
    if (tx_done_set || rx_done_set) begin
      st_d.rd_side[IDX_SER_STATUS] = st_d.rd_side[IDX_SER_STATUS]
                                     | (tx_done_set ? TX_DONE_MASK : REG_RST)
                                     | (rx_done_set ? RX_DONE_MASK : REG_RST);
      st_d.periph.serial_irq = 1'b1;                           // only hardware sets interrupt
    end

    // context save and restore of window select and enable high
    if (push_all_context) begin
      st_d.ctx.window_sel = st_q.rd_side[IDX_WINDOW];
      st_d.ctx.enable_high = st_q.rd_side[IDX_IEN_HI];
    end
    if (pop_all_context) begin
      st_d.rd_side[IDX_WINDOW] = ctx_restore.window_sel & WIN_MASK;
      st_d.rd_side[IDX_IEN_HI] = ctx_restore.enable_high;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // everything clears to zero; the bus is ready straight after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
      st_q.hready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // outputs, each straight from the state register
  // ------------------------------------------------------------
  assign hreadyout = st_q.hready;
  assign hresp = st_q.hresp;
  assign hrdata = st_q.hrdata;
  assign ctx_saved = st_q.ctx;
  assign periph = st_q.periph;
  assign window_select = st_q.rd_side[IDX_WINDOW];

endmodule : sfrwb_bank

// *** rtl/sfrwb_pin_sync.sv ***
// two-stage synchroniser for pin levels entering the bank clock domain
`timescale 1ns/1ns
module sfrwb_pin_sync #(
  parameter int WIDTH = 12
) (
  input wire logic hclk,                     // bank clock
  input wire logic hresetn,                  // async reset, active low
  input wire logic [WIDTH-1:0] async_in,     // raw pin levels
  output logic [WIDTH-1:0] sync_out          // levels safe to use
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] stage1;                // metastable stage, read only by stage2
    logic [WIDTH-1:0] stage2;                // settled stage
  } sfrwb_sync_s;

  sfrwb_sync_s st_q;
  sfrwb_sync_s st_d;

  // refuse an empty synchroniser
  if (WIDTH < 1) begin : g_bad_width
    $error("sfrwb_pin_sync: WIDTH must be at least 1");
  end

  // shift pins through two stages
  always_comb begin
    st_d = st_q;
    st_d.stage1 = async_in;
    st_d.stage2 = st_q.stage1;
  end

  // clear both stages under reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stage2;

endmodule : sfrwb_pin_sync

// *** rtl/sfrwb_pkg.sv ***
// package: register indexes, field masks, reset values and carrier types of the window-switching bank
package sfrwb_pkg;

  // ------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ------------------------------------------------------------
  localparam int IDX_W = 6;                                    // index field width
  localparam int IDX_LSB = 2;                                  // index starts at address bit 2
  localparam logic [IDX_W-1:0] IDX_ZERO_LO = 6'h00;            // zero constant, low byte
  localparam logic [IDX_W-1:0] IDX_ZERO_HI = 6'h01;            // zero constant, high byte
  localparam logic [IDX_W-1:0] IDX_CONV_LO = 6'h02;            // converter result lo / command
  localparam logic [IDX_W-1:0] IDX_CONV_HI = 6'h03;            // converter result hi / capture mode
  localparam logic [IDX_W-1:0] IDX_EVT_LO = 6'h04;             // captured / scheduled time lo
  localparam logic [IDX_W-1:0] IDX_EVT_HI = 6'h05;             // captured / scheduled time hi
  localparam logic [IDX_W-1:0] IDX_CAP_STATUS = 6'h06;         // capture status / scheduled command
  localparam logic [IDX_W-1:0] IDX_SERIAL_BUF = 6'h07;         // receive / transmit buffer
  localparam logic [IDX_W-1:0] IDX_IEN_LO = 6'h08;             // interrupt enable low
  localparam logic [IDX_W-1:0] IDX_IPEND_LO = 6'h09;           // interrupt pending low
  localparam logic [IDX_W-1:0] IDX_TMR_A_LO = 6'h0A;           // first timer lo / watchdog restart
  localparam logic [IDX_W-1:0] IDX_TMR_A_HI = 6'h0B;           // first timer hi / io control third
  localparam logic [IDX_W-1:0] IDX_TMR_B_LO = 6'h0C;           // second timer / capture lo
  localparam logic [IDX_W-1:0] IDX_TMR_B_HI = 6'h0D;           // second timer / capture hi
  localparam logic [IDX_W-1:0] IDX_PIN_IN = 6'h0E;             // first port input / baud divisor
  localparam logic [IDX_W-1:0] IDX_PORT_B = 6'h0F;             // second port
  localparam logic [IDX_W-1:0] IDX_SER_STATUS = 6'h11;         // serial status / serial control
  localparam logic [IDX_W-1:0] IDX_IEN_HI = 6'h13;             // interrupt enable high
  localparam logic [IDX_W-1:0] IDX_WINDOW = 6'h14;             // window select
  localparam logic [IDX_W-1:0] IDX_IOST_A = 6'h15;             // io status first / io control first
  localparam logic [IDX_W-1:0] IDX_IOST_B = 6'h16;             // io status second / io control second
  localparam logic [IDX_W-1:0] IDX_IOST_C = 6'h17;             // io status third / duty cycle
  localparam int NUM_IDX = 26;                                 // indexes 00..19 hex

  // ------------------------------------------------------------
  // windows, field masks and reset values
  // ------------------------------------------------------------
  localparam logic [3:0] WIN_ALT = 4'hF;                       // alternate view
  localparam logic [7:0] CAP_PIN_MASK = 8'hAA;                 // capture status pin-level bits 1,3,5,7
  localparam logic [7:0] IOST_WR_MASK = 8'h3F;                 // bits 6,7 ignore writes
  localparam logic [7:0] FLUSH_MASK = 8'h80;                   // table flush strobe bit
  localparam logic [7:0] TCLR_MASK = 8'h02;                    // second timer clear strobe bit
  localparam logic [7:0] WIN_MASK = 8'h0F;                     // window field of window select
  localparam logic [7:0] RX_DONE_MASK = 8'h40;                 // receive_done_flag in serial status
  localparam logic [7:0] TX_DONE_MASK = 8'h20;                 // transmit_done_flag in serial status
  localparam logic [7:0] REG_RST = 8'h00;                      // reset value of every byte
  localparam logic [7:0] RSVD_READ = 8'h00;                    // value read from reserved places

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [5:0] sched_pins;                                    // output scheduler pin levels
    logic table_flush;                                         // scheduler_table_flush pulse
    logic t2_clear;                                            // second_timer_clear_strobe pulse
    logic serial_irq;                                          // hardware flag set event pulse
  } sfrwb_periph_s;

  typedef struct packed {
    logic [7:0] window_sel;                                    // window select byte
    logic [7:0] enable_high;                                   // interrupt enable high byte
  } sfrwb_ctx_s;

endpackage : sfrwb_pkg
